/* hw/eip_top.sv */
// Edge interrupt port: enables, output latch, pin view and edge flags on APB
`timescale 1ns/1ps
`include "eip_consts.svh"

module eip_top #(
  parameter int N_PINS = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`EIP_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [N_PINS:1] pin_i,
  output logic [N_PINS:1] pin_o,
  output logic [N_PINS:1] pin_oe_n_o,
  output logic [N_PINS:1] irq_o
);

  if (N_PINS < 1 || N_PINS > `EIP_MAX_PINS) begin : g_bad_width
    $error("eip_top: N_PINS out of range");
  end

  localparam int SENS_W = `EIP_SENS_W * N_PINS;

  logic [N_PINS:1] en_q;
  logic [N_PINS:1] en_d;
  logic [N_PINS:1] data_q;
  logic [N_PINS:1] flag_q;
  logic [N_PINS:1] flag_d;
  logic [SENS_W-1:0] sens_q;
  logic [N_PINS:1] oe_n_q;
  logic [N_PINS:1] irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [N_PINS:1] edge_hit;
  logic [N_PINS:1] lvl_mode;
  logic [N_PINS:1] lvl_req;
  logic [N_PINS:1] pin_level;
  logic [N_PINS:1] flag_clr;
  eip_pkg::eip_pin_evt_t [N_PINS-1:0] evt;
  logic setup;
  logic wr_acc;
  logic addr_hit;
  logic [31:0] rd_word;

  // Three-stage synchroniser and edge detect, regardless of direction
  eip_pin_sync #(
    .N_PINS(N_PINS)
  ) u_sync (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(pin_i),
    .evt_o(evt)
  );

  // Per pin mode decode, edge qualification and level request
  for (genvar g = 1; g <= N_PINS; g++) begin : g_pin
    eip_pkg::eip_sens_t mode;
    logic hit;
    assign mode = eip_pkg::eip_sens_t'(sens_q[`EIP_SENS_W*(g-1) +: `EIP_SENS_W]);
    assign pin_level[g] = evt[g-1].level;
    assign lvl_mode[g] = (mode == eip_pkg::EIP_SENS_LEVEL);
    // Level pins are inverted and never latched
    assign lvl_req[g] = lvl_mode[g] & ~evt[g-1].level;
    always_comb begin
      unique case (mode)
        eip_pkg::EIP_SENS_LEVEL: hit = 1'b0;
        eip_pkg::EIP_SENS_FALL: hit = evt[g-1].fall;
        eip_pkg::EIP_SENS_BOTH, eip_pkg::EIP_SENS_BOTH_ALT: hit = evt[g-1].fall | evt[g-1].rise;
      endcase
    end
    // One driver per bit keeps the vector out of several processes
    assign edge_hit[g] = hit;
  end

  // APB decode: one setup cycle then a single access cycle
  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pready_q & pwrite_i;

  always_comb begin
    addr_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr_i)
      `EIP_OFF_IRQ_EN: rd_word[N_PINS:`EIP_PIN_LSB] = en_q;
      `EIP_OFF_OUT_DATA: rd_word[N_PINS:`EIP_PIN_LSB] = data_q;
      `EIP_OFF_PIN_LEVEL: rd_word[N_PINS:`EIP_PIN_LSB] = pin_level;
      `EIP_OFF_EDGE_FLAGS: rd_word[N_PINS:`EIP_PIN_LSB] = flag_q;
      `EIP_OFF_SENS_SEL: rd_word[`EIP_SENS_LSB +: SENS_W] = sens_q;
      `EIP_OFF_DIR_SEL: rd_word[N_PINS:`EIP_PIN_LSB] = ~oe_n_q;
      default: addr_hit = 1'b0;
    endcase
  end

  // Zero wait states; read data captured in the setup cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~addr_hit;
      prdata_q <= (setup & ~pwrite_i) ? rd_word : 32'h0000_0000;
    end
  end

  // Bit zero is reserved, so it is never stored
  always_comb begin
    en_d = en_q;
    if (wr_acc && paddr_i == `EIP_OFF_IRQ_EN) begin
      en_d = pwdata_i[N_PINS:`EIP_PIN_LSB];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_q <= {N_PINS{`EIP_IRQ_EN_RST}};
    end else begin
      en_q <= en_d;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= {N_PINS{`EIP_OUT_DATA_RST}};
    end else if (wr_acc && paddr_i == `EIP_OFF_OUT_DATA) begin
      data_q <= pwdata_i[N_PINS:`EIP_PIN_LSB];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sens_q <= {SENS_W{`EIP_SENS_RST}};
    end else if (wr_acc && paddr_i == `EIP_OFF_SENS_SEL) begin
      sens_q <= pwdata_i[`EIP_SENS_LSB +: SENS_W];
    end
  end

  // Kept inverted so the enable pin comes straight from a flop
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_n_q <= {N_PINS{`EIP_OE_N_RST}};
    end else if (wr_acc && paddr_i == `EIP_OFF_DIR_SEL) begin
      oe_n_q <= ~pwdata_i[N_PINS:`EIP_PIN_LSB];
    end
  end

  // Write-one-to-clear; a new edge in the same cycle wins
  assign flag_clr = (wr_acc && paddr_i == `EIP_OFF_EDGE_FLAGS) ? pwdata_i[N_PINS:`EIP_PIN_LSB] : '0;
  assign flag_d = edge_hit | (flag_q & ~flag_clr);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_q <= {N_PINS{`EIP_FLAG_RST}};
    end else begin
      flag_q <= flag_d;
    end
  end

  // Built from next-state values so enable changes act on the same edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= '0;
    end else begin
      irq_q <= en_d & (flag_d | lvl_req);
    end
  end

  // Pin view has no storage of its own; it shows the synchroniser's filtered level, held while the last two stages disagree
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign pin_o = data_q;
  assign pin_oe_n_o = oe_n_q;
  assign irq_o = irq_q;

  // Checks
  sequence s_rd_setup(logic [`EIP_ADDR_W-1:0] off);
    psel_i && !penable_i && !pwrite_i && paddr_i == off;
  endsequence

  sequence s_wr_access(logic [`EIP_ADDR_W-1:0] off);
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == off;
  endsequence

  a_flag_drives_irq: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (en_q & flag_q & ~irq_o) == '0)
    else $error("enabled flag without interrupt request");

  a_level_drives_irq: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 (en_q & $past(lvl_req) & ~irq_o) == '0)
    else $error("enabled low level pin without request");

  a_disable_drops_irq: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (irq_o & ~en_q) == '0)
    else $error("request present from a disabled pin");

  a_reset_enables_low: assert property (
    @(posedge clock_i)
    $rose(rst_n_i) |-> en_q == '0 && irq_o == '0)
    else $error("enables not cleared by reset");

  a_reset_data_ones: assert property (
    @(posedge clock_i)
    $rose(rst_n_i) |-> data_q == {N_PINS{1'b1}} && pin_o == {N_PINS{1'b1}})
    else $error("output latch not set by reset");

  a_reset_flags_low: assert property (
    @(posedge clock_i)
    $rose(rst_n_i) |-> flag_q == '0)
    else $error("flags not cleared by reset");

  a_data_write_drives: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_access(`EIP_OFF_OUT_DATA) |=> pin_o == $past(pwdata_i[N_PINS:1]))
    else $error("written data not driven to pins");

  a_data_readback: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_rd_setup(`EIP_OFF_OUT_DATA) ##1 penable_i |-> prdata_o[N_PINS:1] == $past(data_q) && prdata_o[0] == 1'b0)
    else $error("output latch read returned wrong value");

  a_pin_view_ro: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_access(`EIP_OFF_PIN_LEVEL) |-> !pslverr_o ##1 $stable(en_q) && $stable(data_q) && $stable(sens_q)
      && $stable(oe_n_q))
    else $error("pin view write altered state or failed");

  a_edge_sets_flag: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    edge_hit != '0 |=> (flag_q & $past(edge_hit)) == $past(edge_hit))
    else $error("detected edge did not set its flag");

  a_flag_w1c: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 ($past(flag_q) & ~$past(flag_clr) & ~flag_q) == '0)
    else $error("flag dropped without a one written");

  a_level_no_flag: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 ($past(lvl_mode) & ~$past(flag_q) & flag_q) == '0)
    else $error("flag set on a level mode pin");

  a_unmapped_error: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup && !addr_hit |=> pready_o && pslverr_o)
    else $error("unmapped access not flagged");

  a_dir_write_oe: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_access(`EIP_OFF_DIR_SEL) |=> pin_oe_n_o == ~$past(pwdata_i[N_PINS:1]))
    else $error("direction write not applied to enables");

  a_enable_write_irq: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_access(`EIP_OFF_IRQ_EN) |=> (irq_o & ~$past(pwdata_i[N_PINS:1])) == '0)
    else $error("request kept after its enable was cleared");

  a_flag_write_clears: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_wr_access(`EIP_OFF_EDGE_FLAGS) |=> (flag_q & $past(pwdata_i[N_PINS:1] & ~edge_hit)) == '0)
    else $error("flag not cleared by a one written");

  a_ready_one_cycle: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup |=> pready_o ##1 !pready_o)
    else $error("ready not a single cycle pulse");

  a_view_tracks_pins: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_rd_setup(`EIP_OFF_PIN_LEVEL) |=> prdata_o[N_PINS:1] == $past(pin_level))
    else $error("pin view read not the live level");

endmodule // eip_top

/* hw/eip_consts.svh */
// Offsets, field positions and reset values of the edge interrupt port
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH

`define EIP_ADDR_W 8
`define EIP_OFF_IRQ_EN 8'h00
`define EIP_OFF_OUT_DATA 8'h04
`define EIP_OFF_PIN_LEVEL 8'h08
`define EIP_OFF_EDGE_FLAGS 8'h0C
`define EIP_OFF_SENS_SEL 8'h10
`define EIP_OFF_DIR_SEL 8'h14

`define EIP_PIN_LSB 1
`define EIP_SENS_LSB 2
`define EIP_SENS_W 2
`define EIP_MAX_PINS 14

`define EIP_IRQ_EN_RST 1'b0
`define EIP_OUT_DATA_RST 1'b1
`define EIP_FLAG_RST 1'b0
`define EIP_SENS_RST 1'b0
`define EIP_OE_N_RST 1'b1
`define EIP_SYNC_RST 1'b1

`endif

/* hw/eip_pkg.sv */
// Types shared by the edge interrupt port modules
package eip_pkg;

  typedef enum logic [1:0] {
    EIP_SENS_LEVEL = 2'h0,
    EIP_SENS_FALL = 2'h1,
    EIP_SENS_BOTH = 2'h2,
    EIP_SENS_BOTH_ALT = 2'h3
  } eip_sens_t;

  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } eip_pin_evt_t;

endpackage

/* hw/eip_pin_sync.sv */
// Pin synchroniser with filtered level and edge pulses
`timescale 1ns/1ps
`include "eip_consts.svh"

module eip_pin_sync #(
  parameter int N_PINS = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [N_PINS-1:0] pin_i,
  output eip_pkg::eip_pin_evt_t [N_PINS-1:0] evt_o
);

  for (genvar g = 0; g < N_PINS; g++) begin : g_pin
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic filt_q;
    logic rise_q;
    logic fall_q;
    logic agree;

    // Idle high so a released reset does not look like a request
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1_q <= `EIP_SYNC_RST;
        s2_q <= `EIP_SYNC_RST;
        s3_q <= `EIP_SYNC_RST;
      end else begin
        s1_q <= pin_i[g];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end

    assign agree = (s2_q == s3_q);

    // Edge seen only once the last two stages agree
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        filt_q <= `EIP_SYNC_RST;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        rise_q <= agree & s3_q & ~filt_q;
        fall_q <= agree & ~s3_q & filt_q;
        if (agree) begin
          filt_q <= s3_q;
        end
      end
    end

    assign evt_o[g].level = filt_q;
    assign evt_o[g].rise = rise_q;
    assign evt_o[g].fall = fall_q;
  end

endmodule // eip_pin_sync

/* bench/eip_pin_model.sv */
// Far-side model: external sources resolved with the port's own drivers
`timescale 1ns/1ps

module eip_pin_model #(
  parameter int N_PINS = 7
) (
  input wire logic [N_PINS:1] ext_level_i,
  input wire logic [N_PINS:1] drv_level_i,
  input wire logic [N_PINS:1] drv_oe_n_i,
  output logic [N_PINS:1] pin_o
);
  // Device drive wins where enabled, so direction tests see real wire levels
  always_comb begin
    for (int i = 1; i <= N_PINS; i++) begin
      pin_o[i] = drv_oe_n_i[i] ? ext_level_i[i] : drv_level_i[i];
    end
  end
endmodule // eip_pin_model

/* bench/eip_top_tb.sv */
// Self-checking bench of the edge interrupt port
`timescale 1ns/1ps

module eip_top_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  logic [7:1] ext = 7'h7F, pin_w, pin_drv, oe_n, irq;
  int mismatches = 0;
  int checks_done = 0;

  always #4 clock_i = ~clock_i;

  eip_top eip_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .pin_i(pin_w), .pin_o(pin_drv), .pin_oe_n_o(oe_n), .irq_o(irq));
  eip_pin_model eip_pin_model_inst (.ext_level_i(ext), .drv_level_i(pin_drv), .drv_oe_n_i(oe_n),
    .pin_o(pin_w));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    // Ends once pready is sampled high; only a wait that never sees it is ended by the watchdog
    do begin
      @(posedge clock_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic t_reset();
    rd_chk("irq_en", 8'h00, 32'h0);
    rd_chk("out_latch", 8'h04, 32'hFE);
    rd_chk("flags", 8'h0C, 32'h0);
    check("pin_o", pin_drv, 7'h7F);
    check("irq", irq, 7'h00);
  endtask

  task automatic t_view();
    ext <= 7'h55;
    cyc(8);
    rd_chk("view", 8'h08, 32'hAA);
    apb(1'b1, 8'h08, 32'h0);
    check("view_wr_err", err, 1'b0);
    rd_chk("view_after", 8'h08, 32'hAA);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped_err", err, 1'b1);
    check("unmapped_rd", rd, 32'h0);
    ext <= 7'h7F;
    cyc(8);
  endtask

  // Pin 2 driven low by the port itself still raises its falling-edge flag
  task automatic t_output();
    apb(1'b1, 8'h10, 32'h10);
    apb(1'b1, 8'h04, 32'hFA);
    apb(1'b1, 8'h14, 32'h04);
    cyc(1);
    check("pin_o", pin_drv, 7'h7D);
    check("oe_n", oe_n, 7'h7D);
    cyc(8);
    rd_chk("flags_out", 8'h0C, 32'h04);
    rd_chk("latch_rd", 8'h04, 32'hFA);
    rd_chk("sens_rd", 8'h10, 32'h10);
    rd_chk("dir_rd", 8'h14, 32'h04);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h04, 32'hFE);
    apb(1'b1, 8'h0C, 32'h04);
    cyc(8);
    rd_chk("flags_clr", 8'h0C, 32'h0);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h10, {28'h0, m[1:0], 2'b00});
      ext[1] <= 1'b0;
      cyc(8);
      rd_chk("flag_fall", 8'h0C, (m != 0) ? 32'h2 : 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      rd_chk("flag_wr0", 8'h0C, (m != 0) ? 32'h2 : 32'h0);
      apb(1'b1, 8'h0C, 32'h2);
      ext[1] <= 1'b1;
      cyc(8);
      rd_chk("flag_rise", 8'h0C, (m >= 2) ? 32'h2 : 32'h0);
      apb(1'b1, 8'h0C, 32'h2);
    end
  endtask

  task automatic t_irq();
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h00, 32'h2);
    ext[1] <= 1'b0;
    cyc(8);
    check("irq_edge", irq, 7'h01);
    apb(1'b1, 8'h0C, 32'h0);
    check("irq_wr0", irq, 7'h01);
    apb(1'b1, 8'h00, 32'h0);
    cyc(1);
    check("irq_dis", irq, 7'h00);
    apb(1'b1, 8'h00, 32'h2);
    cyc(1);
    check("irq_reen", irq, 7'h01);
    apb(1'b1, 8'h0C, 32'h2);
    cyc(1);
    check("irq_clr", irq, 7'h00);
    ext[1] <= 1'b1;
    apb(1'b1, 8'h10, 32'h0);
    cyc(8);
    ext[1] <= 1'b0;
    cyc(8);
    check("irq_level", irq, 7'h01);
    rd_chk("flags_lvl", 8'h0C, 32'h0);
    ext[1] <= 1'b1;
    cyc(8);
    check("irq_lvl_off", irq, 7'h00);
  endtask

  // Second reset in mid-run with state away from its reset values
  task automatic t_reset_mid();
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'hFE);
    ext <= 7'h55;
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(6);
    t_reset();
    check("oe_n_rst", oe_n, 7'h7F);
    rd_chk("view_rst", 8'h08, 32'hAA);
    ext <= 7'h7F;
    cyc(8);
  endtask

  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    cyc(6);
    rst_n_i <= 1'b1;
    cyc(6);
    t_reset();
    t_view();
    t_output();
    t_modes();
    t_irq();
    t_reset_mid();
    end_of_test();
  end
endmodule // eip_top_tb
